// >>> shared/acp_pkg.sv
// Constants, types and field layouts shared by the AGC loop and polar converter.
// Assumes a single 40 MHz clock and synchronous, already-aligned input samples.
// Summary of operation
// - Sync pulse clears accumulator when enable set.
// - Mode bit 0 median, 1 mean settling.
// - Mean mode adds error times loop gain.
// - Median mode steps fixed size, sign-driven direction.
// - Median step from active mantissa and exponent.
// - Selected gain set applies immediately.
// - Gain clamped between limits in both modes.
// - Accumulator growth proportional to loop gain.
// - Converter accepts signed 24-bit I and Q.
// - 24-bit phase, upper bits to formatter.
// - Phase scaled one over two pi.
// - Magnitude unsigned, gain 1.64676, top bit zero.
// - Magnitude MSB weighs four, phase MSB 180.
// - Seventeen iterations then latch results.
// - New sample latches partial results early.
// - Error equals threshold minus magnitude.
// - Loop gain mantissa, exponent weighting.
// - Attack pair decreases, decay pair increases gain.
// - Accumulator limited by 16-bit gain limits.
package acp_pkg;

    localparam int DATA_W   = 24;       // Width of I, Q, magnitude and phase words.
    localparam int CORD_W   = 27;       // Working width of the rotation datapath.
    localparam int FMT_W    = 16;       // Phase bits forwarded to the output formatter.
    localparam int GAIN_W   = 16;       // Width of the gain word and the limits.
    localparam int ACC_W    = 48;       // Loop accumulator width.
    localparam int SUM_W    = 50;       // Signed width used for the limited sum.
    localparam int ERR_W    = 25;       // Signed width of the gain error.
    localparam int PROD_W   = 30;       // Signed width of error times mantissa.
    localparam int ITER_MAX = 17;       // Iterations needed for full precision.
    localparam int MAG_LSB  = 2;        // Working bits dropped to weigh magnitude MSB as four.
    localparam int STEP_SH  = 21;       // Aligns the median step with a unit error.
    localparam int FRAC_W   = ACC_W - GAIN_W;   // Accumulator bits below the gain word.

    localparam logic [DATA_W-1:0] HALF_TURN = 24'h800000;   // Phase of 180 degrees.
    localparam logic [FRAC_W-1:0] FRAC_ZERO = 32'h00000000; // Fill below a limit word.
    localparam logic [4:0]        ITER_ZERO = 5'h00;        // First iteration index.
    localparam logic [4:0]        ITER_ONE  = 5'h01;        // Iteration increment.

    // Arctangent of two to the minus i, in turns scaled by two to the 24.
    localparam logic [DATA_W-1:0] ATAN_TAB [ITER_MAX] = '{
        24'h200000, 24'h12E405, 24'h09FB38, 24'h051112, 24'h028B0D, 24'h0145D8,
        24'h00A2F6, 24'h00517C, 24'h0028BE, 24'h00145F, 24'h000A30, 24'h000518,
        24'h00028C, 24'h000146, 24'h0000A3, 24'h000051, 24'h000029};

    // One stored loop gain set: attack and decay mantissa/exponent pairs.
    typedef struct packed {
        logic [3:0] attack_mantissa;    // Used when the gain must fall.
        logic [3:0] attack_exponent;
        logic [3:0] decay_mantissa;     // Used when the gain must rise.
        logic [3:0] decay_exponent;
    } acp_loop_gain_t;

    // Gain limits; each word is a 4-bit exponent over a 12-bit mantissa.
    typedef struct packed {
        logic [GAIN_W-1:0] upper;
        logic [GAIN_W-1:0] lower;
    } acp_limits_t;

    // Converter sequencing.
    typedef enum logic [0:0] {
        ACP_IDLE,
        ACP_RUN
    } acp_phase_t;

    // Whole state of the block, registered in one place.
    typedef struct packed {
        acp_phase_t                 mode;
        logic [4:0]                 iter;
        logic signed [CORD_W-1:0]   x;
        logic signed [CORD_W-1:0]   y;
        logic [DATA_W-1:0]          z;
        logic [DATA_W-1:0]          mag;
        logic [DATA_W-1:0]          phase;
        logic                       out_valid;
        logic [ACC_W-1:0]           acc;
        logic [GAIN_W-1:0]          gain;
    } acp_state_t;

endpackage : acp_pkg

// >>> logic/acp_agc_polar.sv
// Cartesian-to-polar converter and the AGC loop filter that consumes its magnitude.
// Assumes inputs synchronous to CLK, control ports held steady by software, and one
// input sample per IN_VALID pulse from the filter stage.
module acp_agc_polar #(
    parameter int ITERS = acp_pkg::ITER_MAX     // Iterations before a natural latch.
) (
    input  wire logic                               CLK,
    input  wire logic                               ARST_N,
    input  wire logic                               IN_VALID,
    input  wire logic signed [acp_pkg::DATA_W-1:0]  IN_I,
    input  wire logic signed [acp_pkg::DATA_W-1:0]  IN_Q,
    input  wire logic                               SYNC,
    input  wire logic                               SYNC_CLEAR_EN,
    input  wire logic                               SETTLE_MEAN,
    input  wire logic                               GAIN_SET_SEL,
    input  wire acp_pkg::acp_loop_gain_t            LOOP_GAIN_SET0,
    input  wire acp_pkg::acp_loop_gain_t            LOOP_GAIN_SET1,
    input  wire acp_pkg::acp_limits_t               GAIN_LIMITS,
    input  wire logic [acp_pkg::DATA_W-1:0]         THRESHOLD,
    output logic [acp_pkg::DATA_W-1:0]              MAG,
    output logic [acp_pkg::DATA_W-1:0]              PHASE,
    output logic [acp_pkg::FMT_W-1:0]               PHASE_FMT,
    output logic                                    OUT_VALID,
    output logic [acp_pkg::GAIN_W-1:0]              AGC_GAIN
);

    // The arctangent table holds only full-precision entries, so more are refused.
    if (ITERS < 1 || ITERS > acp_pkg::ITER_MAX) begin : bad_iters
        $error("ITERS must lie between 1 and 17");
    end

    localparam logic [4:0] ITER_LAST = 5'(ITERS - 1);   // Index of the final iteration.

    // Local copies of the package widths so that size casts name a plain constant.
    localparam int CORD_W = acp_pkg::CORD_W;    // Rotation datapath width.
    localparam int ERR_W  = acp_pkg::ERR_W;     // Gain error width.
    localparam int PROD_W = acp_pkg::PROD_W;    // Scaled error width.
    localparam int SUM_W  = acp_pkg::SUM_W;     // Limited sum width.

    acp_pkg::acp_state_t state;         // Registered state of the block.
    acp_pkg::acp_state_t next_state;    // Value it takes at the next edge.

    // Picks the attack or decay pair of the set in force; shared by both settling modes.
    function automatic logic [7:0] pick_gain(input logic sel, input logic rise,
                                             input acp_pkg::acp_loop_gain_t s0,
                                             input acp_pkg::acp_loop_gain_t s1);
        acp_pkg::acp_loop_gain_t s;
        s = sel ? s1 : s0;
        return rise ? {s.decay_mantissa, s.decay_exponent}
                    : {s.attack_mantissa, s.attack_exponent};
    endfunction : pick_gain

    // Converter, error scaling and loop filter in one next-state process.
    always_comb begin
        logic signed [acp_pkg::CORD_W-1:0] xi;      // Extended I input.
        logic signed [acp_pkg::CORD_W-1:0] yi;      // Extended Q input.
        logic signed [acp_pkg::CORD_W-1:0] xs;      // Shifted x for this iteration.
        logic signed [acp_pkg::CORD_W-1:0] ys;      // Shifted y for this iteration.
        logic signed [acp_pkg::ERR_W-1:0]  err;     // Threshold minus magnitude.
        logic signed [acp_pkg::PROD_W-1:0] prod;    // Error times mantissa.
        logic signed [acp_pkg::SUM_W-1:0]  delta;   // Change applied to the sum.
        logic signed [acp_pkg::SUM_W-1:0]  sum;     // Unlimited new sum.
        logic signed [acp_pkg::SUM_W-1:0]  lim_hi;  // Upper limit at sum scale.
        logic signed [acp_pkg::SUM_W-1:0]  lim_lo;  // Lower limit at sum scale.
        logic [7:0]                        lg;      // Active mantissa and exponent.
        logic                              latch;   // Results are latched this cycle.
        xi = '0;
        yi = '0;
        xs = '0;
        ys = '0;
        err = '0;
        prod = '0;
        delta = '0;
        sum = '0;
        lim_hi = '0;
        lim_lo = '0;
        lg = '0;
        latch = 1'b0;
        next_state = state;
        next_state.out_valid = 1'b0;

        // One rotation per clock; y is driven toward zero and z collects the angle.
        if (state.mode == acp_pkg::ACP_RUN) begin
            xs = state.x >>> state.iter;
            ys = state.y >>> state.iter;
            if (!state.y[acp_pkg::CORD_W-1]) begin
                next_state.x = state.x + ys;
                next_state.y = state.y - xs;
                next_state.z = state.z + acp_pkg::ATAN_TAB[state.iter];
            end else begin
                next_state.x = state.x - ys;
                next_state.y = state.y + xs;
                next_state.z = state.z - acp_pkg::ATAN_TAB[state.iter];
            end
            next_state.iter = state.iter + acp_pkg::ITER_ONE;
            if (state.iter == ITER_LAST) begin
                latch = 1'b1;                       // Full precision reached.
                next_state.mode = acp_pkg::ACP_IDLE;
            end
        end

        // A new sample cuts a run short; the partial result is what gets latched.
        if (IN_VALID) begin
            latch = (state.mode == acp_pkg::ACP_RUN);
            xi = CORD_W'(IN_I);
            yi = CORD_W'(IN_Q);
            // Left half-plane vectors are turned by a half turn so rotations converge.
            if (IN_I[acp_pkg::DATA_W-1]) begin
                next_state.x = -xi;
                next_state.y = -yi;
                next_state.z = acp_pkg::HALF_TURN;
            end else begin
                next_state.x = xi;
                next_state.y = yi;
                next_state.z = '0;
            end
            next_state.iter = acp_pkg::ITER_ZERO;
            next_state.mode = acp_pkg::ACP_RUN;
            next_state.gain = state.acc[acp_pkg::ACC_W-1 -: acp_pkg::GAIN_W];
        end

        // The working x carries the 1.64676 rotation gain; dropping two bits sets the
        // MSB weight to four, and since x stays below 2.33 that MSB reads zero.
        if (latch) begin
            next_state.mag = state.x[acp_pkg::MAG_LSB +: acp_pkg::DATA_W];
            next_state.phase = state.z;
            next_state.out_valid = 1'b1;
        end

        // Loop filter runs once per delivered magnitude, in the cycle that it appears.
        if (state.out_valid) begin
            err = ERR_W'(THRESHOLD) - ERR_W'(state.mag);
            // A negative error means the output is too big, so the attack pair applies.
            lg = pick_gain(GAIN_SET_SEL, !err[acp_pkg::ERR_W-1],
                           LOOP_GAIN_SET0, LOOP_GAIN_SET1);
            if (SETTLE_MEAN) begin
                // Proportional step; the fixed 2^-19 weighting lives in the fraction bits.
                prod = PROD_W'(err) * PROD_W'(signed'({1'b0, lg[7:4]}));
                delta = SUM_W'(prod) <<< lg[3:0];
            end else if (err != '0) begin
                // Step size equals the mean step for a unit error, sign only from error.
                delta = (SUM_W'(lg[7:4]) <<< lg[3:0]) <<< acp_pkg::STEP_SH;
                if (err[acp_pkg::ERR_W-1]) begin
                    delta = -delta;
                end
            end
            // A zero mantissa gives a zero delta in both modes.
            sum = SUM_W'(state.acc) + delta;
            lim_hi = SUM_W'({GAIN_LIMITS.upper, acp_pkg::FRAC_ZERO});
            lim_lo = SUM_W'({GAIN_LIMITS.lower, acp_pkg::FRAC_ZERO});
            // Lower limit is checked last so crossed limits resolve to the lower one.
            if (sum > lim_hi) begin
                sum = lim_hi;
            end
            if (sum < lim_lo) begin
                sum = lim_lo;
            end
            next_state.acc = sum[acp_pkg::ACC_W-1:0];
        end

        // Sync clear beats any update landing in the same cycle.
        if (SYNC && SYNC_CLEAR_EN) begin
            next_state.acc = '0;
        end
    end

    // Single state register; reset loads constants only.
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state <= '{mode: acp_pkg::ACP_IDLE, iter: '0, x: '0, y: '0, z: '0, mag: '0,
                       phase: '0, out_valid: 1'b0, acc: '0, gain: '0};
        end else begin
            state <= next_state;
        end
    end

    // Outputs are taken straight from the state register.
    assign MAG       = state.mag;
    assign PHASE     = state.phase;
    assign PHASE_FMT = state.phase[acp_pkg::DATA_W-1 -: acp_pkg::FMT_W];
    assign OUT_VALID = state.out_valid;
    assign AGC_GAIN  = state.gain;

endmodule : acp_agc_polar

// >>> test/acp_monitor.sv
// Checker for converter timing, result hold and AGC gain capture.
// Assumes it is bound to acp_agc_polar with the same ITERS value.
module acp_monitor #(
    parameter int ITERS = 17                     // Iterations of a full run.
) (
    input wire logic                 CLK,
    input wire logic                 ARST_N,
    input wire logic                 IN_VALID,
    input wire logic                 SYNC,
    input wire logic                 SYNC_CLEAR_EN,
    input wire acp_pkg::acp_limits_t GAIN_LIMITS,
    input wire logic [23:0]          MAG,
    input wire logic [23:0]          PHASE,
    input wire logic                 OUT_VALID,
    input wire logic [15:0]          AGC_GAIN
);
    timeunit 1ns;
    timeprecision 1ps;
    logic                 run;  // A sample is being rotated.
    logic [4:0]           cnt;  // Edges since that sample was taken.
    logic                 upd;  // Accumulator is known clamped to the present limits.
    acp_pkg::acp_limits_t lim;  // Limits at the previous edge.
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!ARST_N);
    // A clear or a limit change leaves the accumulator unclamped until its next update.
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            run <= 1'h0;
            cnt <= 5'h00;
            upd <= 1'h0;
            lim <= 32'h00000000;
        end else begin
            run <= IN_VALID | (run & (cnt != ITERS[4:0]));
            cnt <= IN_VALID ? 5'h01 : cnt + 5'h01;
            lim <= GAIN_LIMITS;
            upd <= ((SYNC & SYNC_CLEAR_EN) | (GAIN_LIMITS != lim)) ? 1'h0 : (upd | OUT_VALID);
        end
    end
    full_latch_a: assert property (run && cnt == ITERS[4:0] |=> OUT_VALID)
        else $error("Result not latched after a full run.");
    early_latch_a: assert property (run && IN_VALID |=> OUT_VALID)
        else $error("Partial result not latched on a new sample.");
    no_spurious_a: assert property (!(run && (IN_VALID || cnt == ITERS[4:0])) |=> !OUT_VALID)
        else $error("Result valid without a cause.");
    mag_msb_a: assert property (MAG[23] == 1'h0)
        else $error("Magnitude top bit set.");
    result_hold_a: assert property (!OUT_VALID |-> $stable(MAG) && $stable(PHASE))
        else $error("Result changed without a latch.");
    gain_hold_a: assert property (!$past(IN_VALID) |-> $stable(AGC_GAIN))
        else $error("Gain changed without a new sample.");
    gain_limit_a: assert property (IN_VALID && upd |=> AGC_GAIN <= GAIN_LIMITS.upper && AGC_GAIN >= GAIN_LIMITS.lower)
        else $error("Gain outside its limits.");
    sync_clear_a: assert property (SYNC && SYNC_CLEAR_EN ##1 !OUT_VALID ##1 IN_VALID |=> AGC_GAIN == 16'h0000)
        else $error("Gain not cleared by sync.");
endmodule : acp_monitor

// >>> test/acp_src.sv
// Sample source in place of the filter stage, plus the formatter's result capture.
// Assumes the bench calls send from one process; lines change at falling edges.
module acp_src (
    input  wire logic          clk,
    output logic               in_valid,
    output logic signed [23:0] in_i,
    output logic signed [23:0] in_q,
    input  wire logic          out_valid,
    input  wire logic [23:0]   mag,
    input  wire logic [23:0]   phase
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [23:0] got_mag = 24'h000000;  // Last magnitude taken downstream.
    logic [23:0] got_ph  = 24'h000000;  // Last phase taken downstream.
    // Idle lines start low; the first sample follows reset release.
    initial begin
        in_valid = 1'h0;
        in_i = 24'h000000;
        in_q = 24'h000000;
    end
    // Downstream only trusts the result in the one cycle that valid stands.
    always @(posedge clk) begin
        if (out_valid) begin
            got_mag <= mag;
            got_ph <= phase;
        end
    end
    // One pulse per sample; the inverse follows so that stale data never matches.
    task automatic send(input logic [23:0] i, input logic [23:0] q);
        @(negedge clk);
        in_valid = 1'h1;
        in_i = i;
        in_q = q;
        @(negedge clk);
        in_valid = 1'h0;
        in_i = ~i;
        in_q = ~q;
    endtask : send
endmodule : acp_src

// >>> test/tb_top.sv
// Self-checking bench for the polar converter and its AGC loop.
// Assumes acp_pkg, acp_agc_polar, acp_src and acp_monitor are compiled before it.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int ITERS = 17;                   // Full-precision iterations.
    logic                    clk = 1'h0;         // 40 MHz clock.
    logic                    arst_n = 1'h0;      // Reset, active low.
    logic                    sync = 1'h0;        // Sync pulse.
    logic                    sync_en = 1'h0;     // Sync clear enable.
    logic                    mean = 1'h0;        // Settling mode.
    logic                    sel = 1'h0;         // Gain set select.
    acp_pkg::acp_loop_gain_t set0 = 16'h2B1C;    // Attack 2/11, decay 1/12.
    acp_pkg::acp_loop_gain_t set1 = 16'hFF00;    // Attack 15/15, decay zero.
    acp_pkg::acp_limits_t    lim = 32'h20001000; // Upper and lower gain limits.
    logic [23:0]             thr = 24'h000000;   // Threshold.
    logic                    in_valid;
    logic                    out_valid;
    logic signed [23:0]      in_i;
    logic signed [23:0]      in_q;
    logic [23:0]             mag;
    logic [23:0]             phase;
    logic [15:0]             fmt;
    logic [15:0]             gain;
    int                      bad_count = 0;
    int                      cmp_count = 0;
    // Half period of 12.5 ns.
    always #12.5 clk = ~clk;
    acp_src i_src (.clk(clk), .in_valid(in_valid), .in_i(in_i), .in_q(in_q),
        .out_valid(out_valid), .mag(mag), .phase(phase));
    acp_agc_polar #(.ITERS(ITERS)) i_dut (.CLK(clk), .ARST_N(arst_n), .IN_VALID(in_valid),
        .IN_I(in_i), .IN_Q(in_q), .SYNC(sync), .SYNC_CLEAR_EN(sync_en), .SETTLE_MEAN(mean),
        .GAIN_SET_SEL(sel), .LOOP_GAIN_SET0(set0), .LOOP_GAIN_SET1(set1), .GAIN_LIMITS(lim),
        .THRESHOLD(thr), .MAG(mag), .PHASE(phase), .PHASE_FMT(fmt), .OUT_VALID(out_valid),
        .AGC_GAIN(gain));
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Rotation results are approximate, so a small wrap-aware window is allowed.
    function automatic logic [23:0] near(input logic [23:0] a, input logic [23:0] b);
        logic [23:0] d;
        d = a - b;
        return (d < 24'h000100 || d > 24'hFFFF00) ? 24'h000001 : 24'h000000;
    endfunction : near
    task automatic conclude();
        if (bad_count == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : conclude
    // One full conversion: latency, magnitude, phase and the formatter slice.
    task automatic conv(input logic [23:0] i, q, m, p);
        int n;
        i_src.send(i, q);
        n = 1;
        while (out_valid !== 1'h1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        check(24'(n), 24'(ITERS + 1));
        check({8'h00, fmt}, {8'h00, phase[23:8]});
        @(negedge clk);
        check(near(i_src.got_mag, m), 24'h000001);
        check(near(i_src.got_ph, p), 24'h000001);
    endtask : conv
    // A second sample five cycles in cuts the first short and then runs fully.
    task automatic early();
        i_src.send(24'h400000, 24'h000000);
        repeat (3) @(negedge clk);
        i_src.send(24'h000000, 24'h400000);
        check({23'h000000, out_valid}, 24'h000001);
        repeat (20) @(negedge clk);
        check(near(i_src.got_ph, 24'h400000), 24'h000001);
    endtask : early
    // Sets the loop controls, sends a sample and checks the gain from earlier updates.
    task automatic agc(input logic md, sl, input logic [23:0] t, v, input logic [15:0] e);
        mean = md;
        sel = sl;
        thr = t;
        i_src.send(v, 24'h000000);
        check({8'h00, gain}, {8'h00, e});
        repeat (19) @(negedge clk);
    endtask : agc
    task automatic pulse(input logic en);
        sync_en = en;
        @(negedge clk);
        sync = 1'h1;
        @(negedge clk);
        sync = 1'h0;
    endtask : pulse
    initial begin
        repeat (12) @(negedge clk);
        arst_n = 1'h1;
        agc(1'h1, 1'h0, 24'h100000, 24'h0, 16'h0000);
        agc(1'h1, 1'h0, 24'h100000, 24'h0, 16'h1000);
        agc(1'h0, 1'h0, 24'h000001, 24'h0, 16'h1001);
        agc(1'h0, 1'h0, 24'h000000, 24'h400000, 16'h1003);
        agc(1'h0, 1'h1, 24'h000001, 24'h0, 16'h1001);
        agc(1'h0, 1'h1, 24'h000000, 24'h400000, 16'h1001);
        agc(1'h1, 1'h0, 24'h000000, 24'h0, 16'h1000);
        agc(1'h1, 1'h0, 24'h000001, 24'h0, 16'h1000);
        agc(1'h0, 1'h0, 24'h000001, 24'h0, 16'h1000);
        lim = 32'h10051005;
        agc(1'h0, 1'h0, 24'h000000, 24'h400000, 16'h1002);
        agc(1'h0, 1'h0, 24'h000001, 24'h0, 16'h1005);
        lim = 32'h20001000;
        pulse(1'h0);
        agc(1'h0, 1'h0, 24'h000001, 24'h0, 16'h1005);
        pulse(1'h1);
        agc(1'h0, 1'h0, 24'h000001, 24'h0, 16'h0000);
        agc(1'h0, 1'h0, 24'h000001, 24'h0, 16'h1000);
        conv(24'h400000, 24'h000000, 24'h1A5921, 24'h000000);
        conv(24'h000000, 24'h400000, 24'h1A5921, 24'h400000);
        conv(24'hC00000, 24'h000000, 24'h1A5921, 24'h800000);
        conv(24'h000000, 24'hC00000, 24'h1A5921, 24'hC00000);
        conv(24'h200000, 24'h200000, 24'h12A18C, 24'h200000);
        conv(24'h800000, 24'h800000, 24'h4A8616, 24'hA00000);
        early();
        conclude();
    end
    // The sequence needs about 11.4 us; a hang is cut short well after that.
    initial begin
        #100us;
        bad_count++;
        conclude();
    end
endmodule : tb_top
bind acp_agc_polar acp_monitor #(.ITERS(ITERS)) i_mon (.CLK(CLK), .ARST_N(ARST_N),
    .IN_VALID(IN_VALID), .SYNC(SYNC), .SYNC_CLEAR_EN(SYNC_CLEAR_EN), .GAIN_LIMITS(GAIN_LIMITS),
    .MAG(MAG), .PHASE(PHASE), .OUT_VALID(OUT_VALID), .AGC_GAIN(AGC_GAIN));
